// *** inc/idio_map.svh ***
// register offsets, ident field width and reset values of the relay/input card
// assumes an eight-bit I/O port address relative to the card base
`ifndef IDIO_MAP_SVH
`define IDIO_MAP_SVH
`define IDIO_OFS_GATE 8'h05
`define IDIO_OFS_SRC 8'h07
`define IDIO_OFS_POL 8'h2a
`define IDIO_OFS_RELAY 8'hc0
`define IDIO_OFS_INPUT 8'hc4
`define IDIO_OFS_IDENT 8'hf0
`define IDIO_RST_GATE 8'h00
`define IDIO_RST_POL 8'h00
`define IDIO_RST_RELAY 8'h00
`define IDIO_UNMAPPED 8'h00
`define IDIO_IDENT_W 4
`endif

// *** inc/idio_pkg.sv ***
// shared types of the relay/input card register set
// assumes nothing beyond the map header
package idio_pkg;
  typedef logic [7:0] idio_byte_t;
endpackage

// *** core/idio_sync.sv ***
// two-flop synchroniser, one per bit
// assumes the input is asynchronous to clk_i
`timescale 1ns/10ps
module idio_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  // elaboration check: a zero-width chain has nothing to carry
  if (WIDTH < 1) begin : g_bad_width
    $error("width must be positive");
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule

// *** core/idio_regs.sv ***
// byte-wide I/O port register set: relays, isolated inputs, interrupts, id
// assumes the host holds addr/data stable with a one-cycle rd or wr strobe
`timescale 1ns/10ps
`include "idio_map.svh"

// Behaviour
// R1: status register at 7 shows channel states
// R2: host reads status to find source
// R3: polarity register at 0x2a, 0 inverts
// R4: polarity applies per channel independently
// R5: write at 0xc0 drives eight relays
// R6: read at 0xc0 returns inverted relays
// R7: host xors readback with 0xff
// R8: read at 0xc4 returns isolated inputs
// R9: read at 0xf0 gives id, upper zero
// R10: writing 0xff to mask enables all
// R11: mask bit gates its channel, reset zero
// R12: irq held while enabled channel active
module idio_regs (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] isolated_input_bit_i,
  input wire logic [7:0] interrupt_channel_i,
  input wire logic [`IDIO_IDENT_W-1:0] board_ident_bit_i,
  output idio_pkg::idio_byte_t rdata_o,
  output logic rvalid_o,
  output idio_pkg::idio_byte_t relay_output_bit_o,
  output logic irq_o
);
  logic rst_meta_q;
  logic rst_n_q;
  idio_pkg::idio_byte_t gate_q;
  idio_pkg::idio_byte_t pol_q;
  idio_pkg::idio_byte_t din_s;
  idio_pkg::idio_byte_t chan_s;
  idio_pkg::idio_byte_t irq_source_bit;
  logic [`IDIO_IDENT_W-1:0] ident_s;
  idio_pkg::idio_byte_t rdata_d;

  // reset released through two flops to avoid release skew
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // all pin inputs are asynchronous to the card clock
  idio_sync #(.WIDTH(8)) u_sync_din (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_q),
    .async_i(isolated_input_bit_i),
    .sync_o(din_s)
  );
  idio_sync #(.WIDTH(8)) u_sync_chan (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_q),
    .async_i(interrupt_channel_i),
    .sync_o(chan_s)
  );
  idio_sync #(.WIDTH(`IDIO_IDENT_W)) u_sync_id (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_q),
    .async_i(board_ident_bit_i),
    .sync_o(ident_s)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // polarity-adjusted channel: 1 selects the plain signal
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pol
      assign irq_source_bit[g] = pol_q[g] ? chan_s[g] : ~chan_s[g]; // R3 R4
    end
  endgenerate

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      gate_q <= `IDIO_RST_GATE;
    end else if (wr_i && hit(addr_i, `IDIO_OFS_GATE)) begin
      gate_q <= wdata_i; // R10 R11
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pol_q <= `IDIO_RST_POL;
    end else if (wr_i && hit(addr_i, `IDIO_OFS_POL)) begin
      pol_q <= wdata_i; // R3
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      relay_output_bit_o <= `IDIO_RST_RELAY;
    end else if (wr_i && hit(addr_i, `IDIO_OFS_RELAY)) begin
      relay_output_bit_o <= wdata_i; // R5
    end
  end

  // status writes are ignored: the byte only mirrors the channels
  always_comb begin
    rdata_d = `IDIO_UNMAPPED;
    case (addr_i)
      `IDIO_OFS_GATE: rdata_d = gate_q;
      `IDIO_OFS_SRC: rdata_d = irq_source_bit; // R1
      `IDIO_OFS_POL: rdata_d = pol_q;
      `IDIO_OFS_RELAY: rdata_d = ~relay_output_bit_o; // R6
      `IDIO_OFS_INPUT: rdata_d = din_s; // R8
      `IDIO_OFS_IDENT: rdata_d = {4'h0, ident_s}; // R9
      default: rdata_d = `IDIO_UNMAPPED;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_i;
      if (rd_i) begin
        rdata_o <= rdata_d;
      end
    end
  end

  // level request, no latching: drops one clock after the synchronised cause clears
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_source_bit & gate_q); // R12 R11
    end
  end

  property p_relay_write;
    @(posedge ref_clk_i) disable iff (!rst_n_q)
      wr_i && addr_i == `IDIO_OFS_RELAY |=>
        relay_output_bit_o == $past(wdata_i);
  endproperty
  a_relay_write: assert property (p_relay_write) // R5
    else $error("relay write lost");

  property p_relay_read;
    @(posedge ref_clk_i) disable iff (!rst_n_q)
      rd_i && addr_i == `IDIO_OFS_RELAY |=>
        rdata_o == ~$past(relay_output_bit_o);
  endproperty
  a_relay_read: assert property (p_relay_read) // R6
    else $error("readback not inverted");

  property p_src_read;
    @(posedge ref_clk_i) disable iff (!rst_n_q)
      rd_i && addr_i == `IDIO_OFS_SRC |=>
        rdata_o == ($past(chan_s) ~^ $past(pol_q));
  endproperty
  a_src_read: assert property (p_src_read) // R1
    else $error("status mismatch");

  property p_pol_bit;
    @(posedge ref_clk_i) disable iff (!rst_n_q)
      pol_q == 8'h02 |->
        irq_source_bit == {~chan_s[7:2], chan_s[1], ~chan_s[0]};
  endproperty
  a_pol_bit: assert property (p_pol_bit) // R4
    else $error("polarity not per channel");

  property p_pol_write;
    @(posedge ref_clk_i) disable iff (!rst_n_q)
      wr_i && addr_i == `IDIO_OFS_POL |=> pol_q == $past(wdata_i);
  endproperty
  a_pol_write: assert property (p_pol_write) // R3
    else $error("polarity write lost");

  property p_din_read;
    @(posedge ref_clk_i) disable iff (!rst_n_q)
      rd_i && addr_i == `IDIO_OFS_INPUT |=> rdata_o == $past(din_s);
  endproperty
  a_din_read: assert property (p_din_read) // R8
    else $error("input read wrong");

  property p_id_read;
    @(posedge ref_clk_i) disable iff (!rst_n_q)
      rd_i && addr_i == `IDIO_OFS_IDENT |=>
        rdata_o[7:4] == 4'h0 && rdata_o[3:0] == $past(ident_s);
  endproperty
  a_id_read: assert property (p_id_read) // R9
    else $error("ident read wrong");

  property p_gate_all;
    @(posedge ref_clk_i) disable iff (!rst_n_q)
      wr_i && addr_i == `IDIO_OFS_GATE && wdata_i == 8'hff |=> gate_q == 8'hff;
  endproperty
  a_gate_all: assert property (p_gate_all) // R10
    else $error("enable all failed");

  // reference built apart from the polarity generate, so a slip there shows
  logic irq_ref_s;
  assign irq_ref_s = |((chan_s ~^ pol_q) & gate_q);

  property p_irq_level;
    @(posedge ref_clk_i) disable iff (!rst_n_q)
      irq_o == $past(irq_ref_s);
  endproperty
  a_irq_level: assert property (p_irq_level) // R12
    else $error("irq level wrong");

  property p_gate_off;
    @(posedge ref_clk_i) disable iff (!rst_n_q)
      gate_q == 8'h00 ##1 gate_q == 8'h00 |-> !irq_o;
  endproperty
  a_gate_off: assert property (p_gate_off) // R11
    else $error("masked irq raised");

  c_irq: cover property (@(posedge ref_clk_i) disable iff (!rst_n_q)
    $rose(irq_o));
  c_relay: cover property (@(posedge ref_clk_i) disable iff (!rst_n_q)
    wr_i && addr_i == `IDIO_OFS_RELAY && wdata_i == 8'hff);
  c_src: cover property (@(posedge ref_clk_i) disable iff (!rst_n_q)
    irq_o && rd_i && addr_i == `IDIO_OFS_SRC);
endmodule

// *** sim/idio_host.sv ***
// host model: byte port writes and reads with one-cycle strobes
// assumes the card answers a read exactly one cycle after the strobe
`timescale 1ns/10ps
module idio_host (
  input wire logic clk_i,
  input wire logic rvalid_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] wdata_o
);
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // idle bus shows the inverse so a stale value cannot pass
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  // a late answer yields unknown, never a match
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    d = rvalid_i ? rdata_i : 8'hxx;
    rd_o = 1'b0;
    addr_o = ~a;
  endtask
  task automatic relays(output logic [7:0] d);
    logic [7:0] r;
    get(8'hc0, r);
    d = r ^ 8'hff;
  endtask
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the relay/input card register set
// assumes the host model drives all bus traffic at falling edges
`timescale 1ns/10ps
`include "idio_map.svh"
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr, wdata, rdata, relay, v;
  logic [7:0] din = 8'h00;
  logic [7:0] chan = 8'hff;
  logic [3:0] ident = 4'ha;
  logic wr, rd, rvalid, irq;
  int bad_count = 0;
  int comparisons = 0;
  // pol, mask, channels, status, irq
  logic [7:0] rows [5][5] = '{'{8'h00, 8'hff, 8'hff, 8'h00, 8'h00},
    '{8'h00, 8'hff, 8'hfe, 8'h01, 8'h01}, '{8'h02, 8'h02, 8'h02, 8'hff, 8'h01},
    '{8'h02, 8'h00, 8'h00, 8'hfd, 8'h00}, '{8'hff, 8'h01, 8'hfe, 8'hfe, 8'h00}};
  always #10 clk = ~clk;
  idio_host host (.clk_i(clk), .rvalid_i(rvalid), .rdata_i(rdata),
    .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
  idio_regs dut (.ref_clk_i(clk), .resetn_i(rst_n), .addr_i(addr),
    .wr_i(wr), .rd_i(rd), .wdata_i(wdata), .isolated_input_bit_i(din),
    .interrupt_channel_i(chan), .board_ident_bit_i(ident),
    .rdata_o(rdata), .rvalid_o(rvalid), .relay_output_bit_o(relay),
    .irq_o(irq));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    host.get(`IDIO_OFS_GATE, v);
    chk(v, `IDIO_RST_GATE);
    chk(relay, `IDIO_RST_RELAY);
    for (int i = 0; i < 5; i++) begin
      host.put(`IDIO_OFS_POL, rows[i][0]);
      host.put(`IDIO_OFS_GATE, rows[i][1]);
      chan = rows[i][2];
      repeat (4) @(negedge clk);
      chk({7'h00, irq}, rows[i][4]);
      host.get(`IDIO_OFS_SRC, v);
      chk(v, rows[i][3]);
      host.get(`IDIO_OFS_POL, v);
      chk(v, rows[i][0]);
    end
    // status byte is read-only: a write must leave it alone
    host.put(`IDIO_OFS_SRC, 8'h00);
    host.get(`IDIO_OFS_SRC, v);
    chk(v, 8'hfe);
    host.put(`IDIO_OFS_RELAY, 8'hff);
    chk(relay, 8'hff);
    host.relays(v);
    chk(v, 8'hff);
    host.put(`IDIO_OFS_RELAY, 8'h5a);
    host.get(`IDIO_OFS_RELAY, v);
    chk(v, 8'ha5);
    host.put(`IDIO_OFS_INPUT, 8'h00);
    chk(relay, 8'h5a);
    din = 8'h3c;
    repeat (3) @(negedge clk);
    host.get(`IDIO_OFS_INPUT, v);
    chk(v, 8'h3c);
    host.get(`IDIO_OFS_IDENT, v);
    chk(v, 8'h0a);
    host.get(8'h33, v);
    chk(v, `IDIO_UNMAPPED);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    host.get(`IDIO_OFS_GATE, v);
    chk(v, 8'h00);
    chk(relay, `IDIO_RST_RELAY);
    print_verdict();
  end
endmodule
